// ===== otp_lock_ctrl.v
// Secured region lock control: lock register commands, secured mode and write gating.
`timescale 1ns/1ps
`include "otp_lock_defines.vh"

// How it works
// - Read-lock-state command answers at any time, repeating the register while clocked.
// - Bit 0 shows the factory lock and no command can change it.
// - Write-lock-state may set the customer lock bit; then bit and region freeze.
// - Secured mode blocks every program or erase toward the main array.
// - Write-lock-state runs without any prior write enable.
// - Write-lock-state executes only if chip select rises exactly after the data byte.
// - Region addresses 000-00F hold the serial number, 010-1FF customer data.
// - A factory or customer lock can never be undone.
// - Write-type commands are ignored during the power-up delay after reset.
// - Opcode B1h enters secured mode, C1h leaves it.
// - Secured access refuses register writes; a locked region accepts only reads.
module otp_lock_ctrl
#(
  parameter [23:0] PUW_CYCLES = `PUW_CYCLES
)
(
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // Serial command pins
  input  wire        i_spi_sck,
  input  wire        i_spi_cs_n,
  input  wire        i_spi_mosi,
  output reg         o_spi_miso,
  output wire        o_spi_miso_oe,
  // Non-volatile lock storage
  input  wire        i_nv_factory_lock,
  input  wire        i_nv_customer_lock,
  output reg         o_nv_customer_lock_set,
  // Program and erase path
  input  wire        i_prog_req,
  input  wire        i_erase_req,
  input  wire [23:0] i_prog_addr,
  input  wire [7:0]  i_prog_data,
  output reg         o_prog_rejected,
  // Secured region read path
  input  wire [23:0] i_otp_rd_addr,
  output wire [7:0]  o_otp_rd_data,
  output reg         o_otp_rd_serial,
  // Mode and gating
  output wire        o_secured_mode,
  output wire        o_main_write_block,
  output wire        o_status_write_block,
  output wire        o_write_inhibit,
  output wire [7:0]  o_lock_state
);

  // ============================================================
  // Helpers
  function in_region;
    input [23:0] addr;
    begin
      in_region = (addr <= `OTP_REGION_LAST);
    end
  endfunction

  // A count stuck at its top would lose byte alignment on a long read, so it
  // falls back to a value with the same low bits that never matches a frame length.
  function [5:0] bit_count_inc;
    input [5:0] cnt;
    begin
      bit_count_inc = (cnt == `BITS_SAT) ? `BITS_WRAP : cnt + 6'h01;
    end
  endfunction

  // ============================================================
  // Pin synchronisers
  reg [1:0] sck_sync_r;
  reg [1:0] cs_sync_r;
  reg [1:0] mosi_sync_r;
  reg       sck_prev_r;
  reg       cs_prev_r;

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      sck_sync_r  <= 2'b00;
      cs_sync_r   <= 2'b11;
      mosi_sync_r <= 2'b00;
      sck_prev_r  <= 1'b0;
      cs_prev_r   <= 1'b1;
    end
    else
    begin
      sck_sync_r  <= {sck_sync_r[0], i_spi_sck};
      cs_sync_r   <= {cs_sync_r[0], i_spi_cs_n};
      mosi_sync_r <= {mosi_sync_r[0], i_spi_mosi};
      sck_prev_r  <= sck_sync_r[1];
      cs_prev_r   <= cs_sync_r[1];
    end
  end

  wire sel      = ~cs_sync_r[1];
  wire sck_rise = sel & sck_sync_r[1] & ~sck_prev_r;
  wire sck_fall = sel & ~sck_sync_r[1] & sck_prev_r;
  wire cs_rise  = cs_sync_r[1] & ~cs_prev_r;

  // ============================================================
  // Power-up write inhibit
  reg [23:0] puw_cnt_r;
  reg        puw_busy_r;

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      puw_cnt_r  <= 24'h00_0000;
      puw_busy_r <= 1'b1;
    end
    else if (puw_busy_r)
    begin
      puw_cnt_r <= puw_cnt_r + 24'h00_0001;
      if (puw_cnt_r == PUW_CYCLES - 24'h00_0001)
      begin
        puw_busy_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // Lock state
  // The non-volatile bits are copied in by a clocked load after reset release,
  // never by the reset itself, so storage may settle during reset.
  reg       nv_loaded_r;
  reg       factory_lock_r;
  reg       customer_lock_r;
  reg [5:0] rsvd_r;
  reg       secured_r;

  wire locked     = factory_lock_r | customer_lock_r;
  wire [7:0] lock_state = {rsvd_r, customer_lock_r, factory_lock_r};

  assign o_lock_state         = lock_state;
  assign o_secured_mode       = secured_r;
  assign o_write_inhibit      = puw_busy_r;
  assign o_main_write_block   = secured_r | puw_busy_r;
  assign o_status_write_block = secured_r | puw_busy_r;

  // ============================================================
  // Command shifter
  reg [5:0] bit_cnt_r;
  reg [7:0] opcode_r;
  reg [7:0] data_r;
  reg [7:0] tx_r;
  reg       reading_r;

  wire [7:0] shift_in = {data_r[6:0], mosi_sync_r[1]};
  wire write_ok  = ~puw_busy_r & ~secured_r & ~locked;
  wire frame_end = cs_rise & nv_loaded_r;

  assign o_spi_miso_oe = sel & reading_r;

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      bit_cnt_r <= 6'h00;
      opcode_r  <= 8'h00;
      data_r    <= 8'h00;
      tx_r      <= 8'h00;
      reading_r <= 1'b0;
      o_spi_miso <= 1'b0;
    end
    else if (!sel)
    begin
      bit_cnt_r <= 6'h00;
      reading_r <= 1'b0;
      o_spi_miso <= 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        bit_cnt_r <= bit_count_inc(bit_cnt_r);
        data_r    <= shift_in;
        if (bit_cnt_r == `BITS_OPCODE - 6'h01)
        begin
          opcode_r <= shift_in;
          if (shift_in == `OP_READ_LOCK_STATE)
          begin
            reading_r <= 1'b1;
            tx_r      <= lock_state;
          end
        end
      end
      if (sck_fall && reading_r)
      begin
        o_spi_miso <= tx_r[7];
        tx_r       <= (bit_cnt_r[2:0] == 3'b000) ? {lock_state[6:0], 1'b0}
                                                 : {tx_r[6:0], 1'b0};
        if (bit_cnt_r[2:0] == 3'b000)
        begin
          o_spi_miso <= lock_state[7];
        end
      end
    end
  end

  // ============================================================
  // Command execution at the end of a frame
  wire wr_cmd    = frame_end & (opcode_r == `OP_WRITE_LOCK_STATE);
  wire wr_exact  = wr_cmd & (bit_cnt_r == `BITS_WRITE_FRAME);
  wire enter_cmd = frame_end & (opcode_r == `OP_ENTER_SECURED)
                   & (bit_cnt_r == `BITS_OPCODE);
  wire exit_cmd  = frame_end & (opcode_r == `OP_EXIT_SECURED)
                   & (bit_cnt_r == `BITS_OPCODE);

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      nv_loaded_r            <= 1'b0;
      factory_lock_r         <= 1'b0;
      customer_lock_r        <= 1'b0;
      rsvd_r                 <= `LOCK_RSVD_RESET;
      secured_r              <= 1'b0;
      o_nv_customer_lock_set <= 1'b0;
    end
    else
    begin
      o_nv_customer_lock_set <= 1'b0;
      if (!nv_loaded_r)
      begin
        nv_loaded_r     <= 1'b1;
        factory_lock_r  <= i_nv_factory_lock;
        customer_lock_r <= i_nv_customer_lock;
      end
      else
      begin
        if (wr_exact && write_ok)
        begin
          rsvd_r <= data_r[`LOCK_RSVD_MSB:`LOCK_RSVD_LSB];
          if (data_r[`LOCK_CUSTOMER_BIT])
          begin
            customer_lock_r        <= 1'b1;
            o_nv_customer_lock_set <= 1'b1;
          end
        end
        if (enter_cmd)
        begin
          secured_r <= 1'b1;
        end
        else if (exit_cmd)
        begin
          secured_r <= 1'b0;
        end
      end
    end
  end

  // ============================================================
  // Secured region program path
  wire otp_wr = i_prog_req & secured_r & ~locked & ~puw_busy_r
                & in_region(i_prog_addr);

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_prog_rejected <= 1'b0;
      o_otp_rd_serial <= 1'b0;
    end
    else
    begin
      // Erase never reaches the secured region; main array writes in secured mode fail.
      o_prog_rejected <= (i_prog_req & ~otp_wr & (secured_r | puw_busy_r))
                         | (i_erase_req & (secured_r | puw_busy_r));
      o_otp_rd_serial <= (i_otp_rd_addr <= `OTP_SERIAL_LAST);
    end
  end

  otp_mem u_otp_mem
  (
    .i_clk_sys (i_clk_sys),
    .i_wr_en   (otp_wr),
    .i_wr_addr (i_prog_addr[`OTP_ADDR_W-1:0]),
    .i_wr_data (i_prog_data),
    .i_rd_addr (i_otp_rd_addr[`OTP_ADDR_W-1:0]),
    .o_rd_data (o_otp_rd_data)
  );

endmodule

// ===== otp_lock_ctrl_monitor.sv
// Concurrent property checker for the secured region lock control ports.
`timescale 1ns/1ps
module otp_lock_ctrl_monitor
#(
  parameter [23:0] PUW_CYCLES = 24'h00_0010
)
(
  // Clock and reset
  input wire        i_clk_sys,
  input wire        i_rst,
  // Serial pins
  input wire        i_spi_cs_n,
  input wire        o_spi_miso_oe,
  // Lock storage, program path and read path
  input wire        i_nv_factory_lock,
  input wire        o_nv_customer_lock_set,
  input wire        i_prog_req,
  input wire        i_erase_req,
  input wire [23:0] i_prog_addr,
  input wire        o_prog_rejected,
  input wire [23:0] i_otp_rd_addr,
  input wire        o_otp_rd_serial,
  // Mode and gating
  input wire        o_secured_mode,
  input wire        o_main_write_block,
  input wire        o_status_write_block,
  input wire        o_write_inhibit,
  input wire [7:0]  o_lock_state
);
  // ==========
  // Cycles since reset release; saturates so a long run never wraps it.
  reg [23:0] up_r;
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      up_r <= 24'h00_0000;
    else if (up_r != 24'hFF_FFFF)
      up_r <= up_r + 24'h00_0001;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========
  // Properties.
  a_reset_state: assert property (disable iff (1'b0) i_rst |=>
    o_lock_state == 8'h00 && !o_secured_mode && o_write_inhibit) else $error("bad reset state");
  a_inhibit_early: assert property (up_r < PUW_CYCLES - 24'h00_0002 |-> o_write_inhibit)
    else $error("write inhibit ended early");
  a_inhibit_late: assert property (up_r > PUW_CYCLES + 24'h00_0002 |-> !o_write_inhibit)
    else $error("write inhibit ended late");
  a_factory_bit_fixed: assert property (up_r > 24'h00_0003 |-> $stable(o_lock_state[0]))
    else $error("factory lock bit changed");
  a_factory_load: assert property (up_r == 24'h00_0001 |->
    o_lock_state[0] == $past(i_nv_factory_lock)) else $error("factory lock not loaded");
  a_drive_selected: assert property (o_spi_miso_oe |-> !$past(i_spi_cs_n, 2))
    else $error("miso driven while deselected");
  a_lock_sticks: assert property (up_r > 24'h00_0003 && $past(o_lock_state[1])
    |-> o_lock_state[1]) else $error("customer lock cleared");
  a_set_pulse: assert property (o_nv_customer_lock_set |-> !o_secured_mode
    ##1 !o_nv_customer_lock_set && o_lock_state[1]) else $error("bad lock commit pulse");
  a_block_levels: assert property (o_main_write_block == (o_secured_mode | o_write_inhibit)
    && o_status_write_block == o_main_write_block) else $error("bad write block level");
  a_secured_reject: assert property (o_secured_mode && (i_erase_req ||
    (i_prog_req && i_prog_addr > 24'h00_01FF)) |=> o_prog_rejected) else $error("not rejected");
  a_inhibit_reject: assert property (o_write_inhibit && (i_prog_req || i_erase_req)
    |=> o_prog_rejected) else $error("not rejected in inhibit");
  a_reject_cause: assert property (!(i_prog_req || i_erase_req) |=> !o_prog_rejected)
    else $error("reject without request");
  a_serial_flag: assert property (up_r > 24'h00_0001 |->
    o_otp_rd_serial == ($past(i_otp_rd_addr) <= 24'h00_000F)) else $error("bad serial flag");
  c_lock_set: cover property (o_nv_customer_lock_set);
  c_rejected: cover property (o_prog_rejected && !o_write_inhibit);
  c_secured: cover property ($rose(o_secured_mode));
  c_read_drive: cover property ($rose(o_spi_miso_oe));
endmodule

// ===== otp_lock_defines.vh
// Constants for the secured one-time-programmable region and its lock register.
`ifndef OTP_LOCK_DEFINES_VH
`define OTP_LOCK_DEFINES_VH

// ============================================================
// Command opcodes
`define OP_READ_LOCK_STATE   8'h2B
`define OP_WRITE_LOCK_STATE  8'h2F
`define OP_ENTER_SECURED     8'hB1
`define OP_EXIT_SECURED      8'hC1

// ============================================================
// Lock register fields
`define LOCK_FACTORY_BIT     0
`define LOCK_CUSTOMER_BIT    1
`define LOCK_RSVD_LSB        2
`define LOCK_RSVD_MSB        7
`define LOCK_RSVD_RESET      6'h00

// ============================================================
// Frame lengths and bit count limits in serial clock edges
`define BITS_OPCODE          6'h08
`define BITS_WRITE_FRAME     6'h10
`define BITS_SAT             6'h3F
`define BITS_WRAP            6'h38

// ============================================================
// Secured region map
`define OTP_ADDR_W           9
`define OTP_DEPTH            512
`define OTP_SERIAL_LAST      24'h00_000F
`define OTP_REGION_LAST      24'h00_01FF

// ============================================================
// Power-up write inhibit
`define CLK_MHZ              200
`define PUW_MIN_MS           1
`define PUW_MAX_MS           10
// One millisecond at 200 MHz, the shortest delay allowed.
`define PUW_CYCLES           24'h03_0D40

`endif

// ===== otp_mem.v
// Byte-wide storage of the secured region with a registered read port.
`timescale 1ns/1ps
`include "otp_lock_defines.vh"

module otp_mem
(
  // Clock
  input  wire                   i_clk_sys,
  // Write port
  input  wire                   i_wr_en,
  input  wire [`OTP_ADDR_W-1:0] i_wr_addr,
  input  wire [7:0]             i_wr_data,
  // Read port
  input  wire [`OTP_ADDR_W-1:0] i_rd_addr,
  output reg  [7:0]             o_rd_data
);

  reg [7:0] mem [0:`OTP_DEPTH-1];

  always @(posedge i_clk_sys)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end

endmodule

// ===== spi_host_model.sv
// Behavioural serial host that frames commands on chip select, clock and data.
`timescale 1ns/1ps
module spi_host_model
(
  // Clock
  input  wire i_clk_sys,
  // Serial pins
  input  wire i_miso,
  output reg  o_sck,
  output reg  o_cs_n,
  output reg  o_mosi
);
  // ==========
  // Each clock phase lasts eight system clocks so the synchronised miso settles.
  localparam int HALF = 8;
  reg [31:0] rx_r;
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
    rx_r   = 32'h0000_0000;
  end
  task automatic frame(input logic [31:0] bits, input int n);
    begin
      @(negedge i_clk_sys);
      o_cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
        o_mosi = bits[31-i];
        repeat (HALF) @(negedge i_clk_sys);
        o_sck = 1'b1;
        rx_r = {rx_r[30:0], i_miso};
        repeat (HALF) @(negedge i_clk_sys);
        o_sck = 1'b0;
      end
      repeat (HALF) @(negedge i_clk_sys);
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      repeat (HALF) @(negedge i_clk_sys);
    end
  endtask
endmodule

// ===== tb_otp_lock_ctrl.sv
// Self-checking bench for the secured region lock control.
`timescale 1ns/1ps
module tb_otp_lock_ctrl;
  localparam [23:0] PUW = 24'h00_0258;
  reg         i_clk_sys, i_rst, i_nv_factory_lock, i_nv_customer_lock, i_prog_req, i_erase_req;
  reg  [23:0] i_prog_addr, i_otp_rd_addr;
  reg  [7:0]  i_prog_data;
  wire        sck, cs_n, mosi, miso, lock_set, rejected, rd_serial, secured, mblk, sblk, inhibit;
  wire [7:0]  rd_data, lock_state;
  int         n_mismatch, n_compared;
  spi_host_model host (.i_clk_sys(i_clk_sys), .i_miso(miso), .o_sck(sck), .o_cs_n(cs_n),
    .o_mosi(mosi));
  otp_lock_ctrl #(.PUW_CYCLES(PUW)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
    .o_spi_miso_oe(), .i_nv_factory_lock(i_nv_factory_lock),
    .i_nv_customer_lock(i_nv_customer_lock), .o_nv_customer_lock_set(lock_set),
    .i_prog_req(i_prog_req), .i_erase_req(i_erase_req), .i_prog_addr(i_prog_addr),
    .i_prog_data(i_prog_data), .o_prog_rejected(rejected), .i_otp_rd_addr(i_otp_rd_addr),
    .o_otp_rd_data(rd_data), .o_otp_rd_serial(rd_serial), .o_secured_mode(secured),
    .o_main_write_block(mblk), .o_status_write_block(sblk), .o_write_inhibit(inhibit),
    .o_lock_state(lock_state));
  // ==========
  // Shared tasks.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Requests one program or erase; returns where the reject pulse is visible.
  task prog(input [23:0] a, input [7:0] d, input e);
    begin
      @(negedge i_clk_sys);
      {i_prog_addr, i_prog_data, i_prog_req, i_erase_req} = {a, d, ~e, e};
      @(negedge i_clk_sys);
      {i_prog_req, i_erase_req} = 2'b00;
    end
  endtask
  task rd(input [23:0] a, input [7:0] exp, input ser);
    begin
      @(negedge i_clk_sys);
      i_otp_rd_addr = a;
      @(negedge i_clk_sys);
      chk(rd_data, exp);
      chk(rd_serial, ser);
    end
  endtask
  task do_reset;
    begin
      i_rst = 1'b1;
      repeat (20) @(negedge i_clk_sys);
      i_rst = 1'b0;
      repeat (3) @(negedge i_clk_sys);
    end
  endtask
  // ==========
  // Scenarios.
  task t_power_up;
    begin
      chk({inhibit, lock_state}, 9'h100);
      prog(24'h00_0100, 8'h11, 1'b0);
      chk(rejected, 1'b1);
      host.frame(32'h2F02_0000, 16);
      chk(lock_state, 8'h00);
      repeat (PUW) @(negedge i_clk_sys);
      chk(inhibit, 1'b0);
      $display("done: power up");
    end
  endtask
  task t_secured;
    begin
      host.frame(32'hB100_0000, 8);
      chk(secured, 1'b1);
      prog(24'h00_0205, 8'h22, 1'b0);
      chk(rejected, 1'b1);
      prog(24'h00_0000, 8'h00, 1'b1);
      chk(rejected, 1'b1);
      prog(24'h00_0003, 8'hA5, 1'b0);
      chk(rejected, 1'b0);
      prog(24'h00_0010, 8'h3C, 1'b0);
      rd(24'h00_0003, 8'hA5, 1'b1);
      rd(24'h00_0010, 8'h3C, 1'b0);
      host.frame(32'h2F02_0000, 16);
      chk(lock_state, 8'h00);
      host.frame(32'hC100_0000, 8);
      chk(secured, 1'b0);
      prog(24'h00_0205, 8'h22, 1'b0);
      chk(rejected, 1'b0);
      $display("done: secured mode");
    end
  endtask
  task t_boundary;
    begin
      host.frame(32'h2F02_0000, 15);
      chk(lock_state, 8'h00);
      host.frame(32'h2F02_0000, 17);
      chk(lock_state, 8'h00);
      $display("done: frame boundary");
    end
  endtask
  task t_lock;
    begin
      host.frame(32'h2FA7_0000, 16);
      chk(lock_state, 8'hA6);
      host.frame(32'h2F00_0000, 16);
      chk(lock_state, 8'hA6);
      host.frame(32'hB100_0000, 8);
      host.frame(32'h2B00_0000, 24);
      chk(host.rx_r[15:0], 16'hA6A6);
      prog(24'h00_0003, 8'h5A, 1'b0);
      chk(rejected, 1'b1);
      rd(24'h00_0003, 8'hA5, 1'b1);
      host.frame(32'hC100_0000, 8);
      $display("done: customer lock");
    end
  endtask
  task t_nv_reload;
    begin
      {i_nv_factory_lock, i_nv_customer_lock} = 2'b11;
      do_reset;
      chk(lock_state, 8'h03);
      repeat (PUW) @(negedge i_clk_sys);
      host.frame(32'h2F00_0000, 16);
      chk(lock_state, 8'h03);
      $display("done: stored locks");
    end
  endtask
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    #250_000;
    n_mismatch++;
    give_verdict;
  end
  initial
  begin
    {n_mismatch, n_compared} = 0;
    {i_rst, i_nv_factory_lock, i_nv_customer_lock, i_prog_req, i_erase_req} = 5'b10000;
    {i_prog_addr, i_otp_rd_addr, i_prog_data} = 56'h0;
    do_reset;
    t_power_up;
    t_secured;
    t_boundary;
    t_lock;
    t_nv_reload;
    give_verdict;
  end
endmodule
bind otp_lock_ctrl otp_lock_ctrl_monitor #(.PUW_CYCLES(PUW_CYCLES)) mon (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n), .o_spi_miso_oe(o_spi_miso_oe),
  .i_nv_factory_lock(i_nv_factory_lock),
  .o_nv_customer_lock_set(o_nv_customer_lock_set), .i_prog_req(i_prog_req),
  .i_erase_req(i_erase_req), .i_prog_addr(i_prog_addr), .o_prog_rejected(o_prog_rejected),
  .i_otp_rd_addr(i_otp_rd_addr), .o_otp_rd_serial(o_otp_rd_serial),
  .o_secured_mode(o_secured_mode), .o_main_write_block(o_main_write_block),
  .o_status_write_block(o_status_write_block), .o_write_inhibit(o_write_inhibit),
  .o_lock_state(o_lock_state));
